// [src/irf_pkg.sv]
package irf_pkg;
    localparam logic [3:0] IRF_ADDR_EXT_FLAGS   = 4'h0;
    localparam logic [3:0] IRF_ADDR_TMR_FLAGS   = 4'h1;
    localparam logic [3:0] IRF_ADDR_PER_FLAGS   = 4'h2;
    localparam logic [3:0] IRF_ADDR_EDGE_SEL    = 4'h3;
    localparam logic [3:0] IRF_ADDR_EXT_ENABLE  = 4'h4;
    localparam logic [3:0] IRF_ADDR_TMR_ENABLE  = 4'h5;
    localparam logic [3:0] IRF_ADDR_PER_ENABLE  = 4'h6;
    localparam logic [3:0] IRF_ADDR_PORT_MODE   = 4'h7;
    localparam logic [3:0] IRF_ADDR_CONTROL     = 4'h8;
    localparam logic [3:0] IRF_ADDR_SELECTED    = 4'h9;

    localparam logic [7:0] IRF_EXT_FIXED_ONES   = 8'hc0;
    localparam logic [7:0] IRF_EXT_FLAG_MASK    = 8'h3f;
    localparam logic [7:0] IRF_TMR_FLAG_MASK    = 8'h3f;
    localparam logic [7:0] IRF_PER_FIXED_ONES   = 8'h3c;
    localparam logic [7:0] IRF_PER_FLAG_MASK    = 8'hc3;
    localparam logic [7:0] IRF_EDGE_FIXED_ONES  = 8'hec;
    localparam logic [7:0] IRF_EDGE_MASK        = 8'h13;
    localparam logic [7:0] IRF_RESET_ZERO       = 8'h00;

    // edge select bit positions
    localparam int IRF_EDGE_BIT_L4 = 4;
    localparam int IRF_EDGE_BIT_L1 = 1;
    localparam int IRF_EDGE_BIT_L0 = 0;
    // control register bits
    localparam int IRF_CTL_GMASK  = 0;
    localparam int IRF_CTL_NOISE  = 1;

    localparam int          IRF_NOISE_STATES = 256;
    localparam logic [7:0]  IRF_NOISE_LAST   = 8'(IRF_NOISE_STATES - 1);

    typedef struct packed {
        logic [4:0] timer_ovf;
        logic       direct_xfer;
        logic       conv_done;
        logic       key_scan;
        logic       serial2;
        logic       serial1;
    } irf_events_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] source;
    } irf_request_s;
endpackage

// [src/irf_edge_line.sv]
`timescale 1ns/1ps
module irf_edge_line (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and configuration
    input  wire logic pin,
    input  wire logic rising,
    input  wire logic pin_used,
    // result
    output logic      edge_hit
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic hit_w;

    assign hit_w = rising ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign edge_hit = hit_w & pin_used;
endmodule

// [src/irf_noise_filter.sv]
`timescale 1ns/1ps
module irf_noise_filter (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // sample input
    input  wire logic level_in,
    // filtered level
    output logic      level_out
);
    import irf_pkg::*;

    logic [7:0] cnt_q;
    logic       first_q;
    logic       out_q;
    logic       tick_w;

    assign tick_w = (cnt_q == IRF_NOISE_LAST);

    // two samples 256 states apart must agree
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q   <= IRF_RESET_ZERO;
            first_q <= 1'b1;
            out_q   <= 1'b1;
        end else begin
            cnt_q   <= cnt_q + 8'h01;
            if (tick_w) begin
                first_q <= level_in;
                if (first_q == level_in) begin
                    out_q <= level_in;
                end
            end
        end
    end

    assign level_out = out_q;
endmodule

// [src/irf_flag_unit.sv]
`timescale 1ns/1ps
module interrupt_request_flag_unit (
    // clock and reset
    input  wire logic               CORE_CLK,
    input  wire logic               RESET,
    // register port
    input  wire logic [3:0]         REG_ADDR,
    input  wire logic [7:0]         REG_WDATA,
    input  wire logic               REG_WRITE,
    input  wire logic               REG_READ,
    output logic      [7:0]         REG_RDATA,
    // external interrupt pins, active low
    input  wire logic [5:0]         EXTERNAL_INTERRUPT_PINS,
    // peripheral request pulses
    input  wire irf_pkg::irf_events_s PERIPH_EVENTS,
    // cpu side
    input  wire logic               CPU_ACCEPT,
    output irf_pkg::irf_request_s   CPU_REQUEST,
    output logic                    GLOBAL_MASK
);
    import irf_pkg::*;

    logic [5:0] ext_flags_q;
    logic [5:0] tmr_flags_q;
    logic [3:0] per_flags_q;
    logic [7:0] edge_sel_q;
    logic [5:0] ext_en_q;
    logic [7:0] tmr_en_q;
    logic [3:0] per_en_q;
    logic [5:0] port_mode_q;
    logic       noise_on_q;
    logic       gmask_q;
    logic [7:0] rdata_q;
    irf_request_s req_q;

    logic [5:0] ext_flags_d;
    logic [5:0] tmr_flags_d;
    logic [3:0] per_flags_d;
    logic [5:0] edge_hits;
    logic [5:0] line_rising;
    logic [5:0] pin_levels;
    logic       filt0;
    logic [5:0] ext_set;
    logic [5:0] tmr_set;
    logic [3:0] per_set;
    logic [5:0] ext_keep;
    logic [5:0] tmr_keep;
    logic [3:0] per_keep;
    logic       wr_ext;
    logic       wr_tmr;
    logic       wr_per;
    logic [15:0] pending;
    logic [3:0] sel_src;
    logic       sel_valid;
    logic       sel_is_ext;
    logic [7:0] rd_mux;
    logic       gmask_d;

    // line 0 optionally filtered
    irf_noise_filter u_noise (
        .clk       (CORE_CLK),
        .rst       (RESET),
        .level_in  (EXTERNAL_INTERRUPT_PINS[0]),
        .level_out (filt0)
    );

    assign pin_levels = {EXTERNAL_INTERRUPT_PINS[5:1],
                         noise_on_q ? filt0 : EXTERNAL_INTERRUPT_PINS[0]};

    // lines 5,3,2 are falling only
    assign line_rising = {1'b0, edge_sel_q[IRF_EDGE_BIT_L4], 1'b0, 1'b0,
                          edge_sel_q[IRF_EDGE_BIT_L1], edge_sel_q[IRF_EDGE_BIT_L0]};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_line
            irf_edge_line u_line (
                .clk      (CORE_CLK),
                .rst      (RESET),
                .pin      (pin_levels[gi]),
                .rising   (line_rising[gi]),
                .pin_used (port_mode_q[gi]),
                .edge_hit (edge_hits[gi])
            );
        end
    endgenerate

    // set sources
    assign ext_set = edge_hits;
    assign tmr_set = {PERIPH_EVENTS.direct_xfer, PERIPH_EVENTS.timer_ovf};
    assign per_set = {PERIPH_EVENTS.conv_done, PERIPH_EVENTS.key_scan,
                      PERIPH_EVENTS.serial2, PERIPH_EVENTS.serial1};

    // write decode
    assign wr_ext = REG_WRITE && (REG_ADDR == IRF_ADDR_EXT_FLAGS);
    assign wr_tmr = REG_WRITE && (REG_ADDR == IRF_ADDR_TMR_FLAGS);
    assign wr_per = REG_WRITE && (REG_ADDR == IRF_ADDR_PER_FLAGS);

    // writing 1 keeps the flag, writing 0 clears it
    assign ext_keep = wr_ext ? REG_WDATA[5:0] : 6'h3f;
    assign tmr_keep = wr_tmr ? REG_WDATA[5:0] : 6'h3f;
    assign per_keep = wr_per ? {REG_WDATA[7:6], REG_WDATA[1:0]} : 4'hf;

    // set wins over clear; acceptance never clears
    assign ext_flags_d = (ext_flags_q & ext_keep) | ext_set;
    assign tmr_flags_d = (tmr_flags_q & tmr_keep) | tmr_set;
    assign per_flags_d = (per_flags_q & per_keep) | per_set;

    // enabled pending requests in priority order, line 0 first
    assign pending = {per_flags_q & per_en_q,
                      tmr_flags_q & tmr_en_q[5:0],
                      ext_flags_q & ext_en_q};

    always_comb begin
        sel_src   = 4'h0;
        sel_valid = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (pending[i]) begin
                sel_src   = 4'(i);
                sel_valid = 1'b1;
            end
        end
    end

    assign sel_is_ext = req_q.valid && (req_q.source < 4'h6);
    assign gmask_d    = (REG_WRITE && (REG_ADDR == IRF_ADDR_CONTROL)) ? REG_WDATA[IRF_CTL_GMASK] : gmask_q;

    // read mux
    always_comb begin
        case (REG_ADDR)
            IRF_ADDR_EXT_FLAGS:  rd_mux = IRF_EXT_FIXED_ONES | {2'b00, ext_flags_q};
            IRF_ADDR_TMR_FLAGS:  rd_mux = {2'b00, tmr_flags_q};
            IRF_ADDR_PER_FLAGS:  rd_mux = IRF_PER_FIXED_ONES | {per_flags_q[3:2], 4'h0, per_flags_q[1:0]};
            IRF_ADDR_EDGE_SEL:   rd_mux = IRF_EDGE_FIXED_ONES | edge_sel_q;
            IRF_ADDR_EXT_ENABLE: rd_mux = IRF_EXT_FIXED_ONES | {2'b00, ext_en_q};
            IRF_ADDR_TMR_ENABLE: rd_mux = tmr_en_q;
            IRF_ADDR_PER_ENABLE: rd_mux = IRF_PER_FIXED_ONES | {per_en_q[3:2], 4'h0, per_en_q[1:0]};
            IRF_ADDR_PORT_MODE:  rd_mux = {2'b00, port_mode_q};
            IRF_ADDR_CONTROL:    rd_mux = {6'h00, noise_on_q, gmask_q};
            IRF_ADDR_SELECTED:   rd_mux = {3'h0, req_q.valid, req_q.source};
            default:             rd_mux = IRF_RESET_ZERO;
        endcase
    end

    // flags
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ext_flags_q <= 6'h00;
            tmr_flags_q <= 6'h00;
            per_flags_q <= 4'h0;
        end else begin
            ext_flags_q <= ext_flags_d;
            tmr_flags_q <= tmr_flags_d;
            per_flags_q <= per_flags_d;
        end
    end

    // configuration registers
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            edge_sel_q  <= IRF_RESET_ZERO;
            ext_en_q    <= 6'h00;
            tmr_en_q    <= IRF_RESET_ZERO;
            per_en_q    <= 4'h0;
            port_mode_q <= 6'h00;
            noise_on_q  <= 1'b0;
        end else if (REG_WRITE) begin
            case (REG_ADDR)
                IRF_ADDR_EDGE_SEL:   edge_sel_q  <= REG_WDATA & IRF_EDGE_MASK;
                IRF_ADDR_EXT_ENABLE: ext_en_q    <= REG_WDATA[5:0];
                IRF_ADDR_TMR_ENABLE: tmr_en_q    <= REG_WDATA;
                IRF_ADDR_PER_ENABLE: per_en_q    <= {REG_WDATA[7:6], REG_WDATA[1:0]};
                IRF_ADDR_PORT_MODE:  port_mode_q <= REG_WDATA[5:0];
                IRF_ADDR_CONTROL:    noise_on_q  <= REG_WDATA[IRF_CTL_NOISE];
                default:             noise_on_q  <= noise_on_q;
            endcase
        end
    end

    // global mask: software writes it, accepting an external request sets it
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            gmask_q <= 1'b1;
        end else if (CPU_ACCEPT && sel_is_ext) begin
            gmask_q <= 1'b1;
        end else begin
            gmask_q <= gmask_d;
        end
    end

    // request to cpu held off by global mask
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            req_q <= '0;
        end else begin
            req_q.valid  <= sel_valid & ~gmask_q;
            req_q.source <= sel_src;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rdata_q <= IRF_RESET_ZERO;
        end else if (REG_READ) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= IRF_RESET_ZERO;
        end
    end

    assign REG_RDATA   = rdata_q;
    assign CPU_REQUEST = req_q;
    assign GLOBAL_MASK = gmask_q;
endmodule

// [testbench/irf_flag_sva.sv]
`timescale 1ns/1ps
module irf_flag_sva (
    // clock and reset
    input wire logic                  CORE_CLK,
    input wire logic                  RESET,
    // register port
    input wire logic [3:0]            REG_ADDR,
    input wire logic [7:0]            REG_WDATA,
    input wire logic                  REG_WRITE,
    input wire logic                  REG_READ,
    input wire logic [7:0]            REG_RDATA,
    // requesters
    input wire logic [5:0]            EXTERNAL_INTERRUPT_PINS,
    input wire irf_pkg::irf_events_s  PERIPH_EVENTS,
    // cpu side
    input wire logic                  CPU_ACCEPT,
    input wire irf_pkg::irf_request_s CPU_REQUEST,
    input wire logic                  GLOBAL_MASK
);
    import irf_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    wire rd_ext = REG_READ && REG_ADDR == IRF_ADDR_EXT_FLAGS;
    wire rd_tmr = REG_READ && REG_ADDR == IRF_ADDR_TMR_FLAGS;
    wire rd_per = REG_READ && REG_ADDR == IRF_ADDR_PER_FLAGS;
    // reads that follow an event with no write between
    sequence per_later_s;
        !REG_WRITE [*3] ##1 rd_per;
    endsequence

    ext_fixed_a: assert property (rd_ext |=> REG_RDATA[7:6] == 2'h3)
        else $error("ext fixed bits wrong");
    per_fixed_a: assert property (rd_per |=> REG_RDATA[5:2] == 4'hf)
        else $error("periph fixed bits wrong");
    tmr_top_a: assert property (rd_tmr |=> REG_RDATA[7:6] == 2'h0)
        else $error("timer top bits wrong");
    timer_set_a: assert property (|PERIPH_EVENTS.timer_ovf ##1 !REG_WRITE ##1 rd_tmr
        |=> &(REG_RDATA[4:0] | ~$past(PERIPH_EVENTS.timer_ovf, 3))) else $error("timer flag lost");
    conv_set_a: assert property (PERIPH_EVENTS.conv_done ##1 per_later_s |=> REG_RDATA[7])
        else $error("converter flag lost");
    serial_set_a: assert property (PERIPH_EVENTS.serial1 ##1 per_later_s |=> REG_RDATA[0])
        else $error("serial flag lost");
    mask_hold_a: assert property (GLOBAL_MASK && $past(GLOBAL_MASK) |-> !CPU_REQUEST.valid)
        else $error("request passed the mask");
    accept_mask_a: assert property (CPU_ACCEPT && CPU_REQUEST.valid && CPU_REQUEST.source <= 4'h5
        && !REG_WRITE |=> GLOBAL_MASK) else $error("mask not set on accept");
    mask_write_a: assert property (REG_WRITE && REG_ADDR == IRF_ADDR_CONTROL && REG_WDATA[IRF_CTL_GMASK]
        |=> GLOBAL_MASK) else $error("mask write lost");

    cover property (CPU_ACCEPT && CPU_REQUEST.valid);
    cover property (REG_WRITE && REG_ADDR == IRF_ADDR_EXT_FLAGS);
    cover property (PERIPH_EVENTS.conv_done ##1 per_later_s);
endmodule

bind interrupt_request_flag_unit irf_flag_sva chk_u (.CORE_CLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WRITE,
    .REG_READ, .REG_RDATA, .EXTERNAL_INTERRUPT_PINS, .PERIPH_EVENTS, .CPU_ACCEPT, .CPU_REQUEST, .GLOBAL_MASK);

// [testbench/irf_far_model.sv]
`timescale 1ns/1ps
module irf_far_model (
    // clock
    input  wire logic           clk,
    // pins, peripherals and cpu
    output logic [5:0]          pins,
    output irf_pkg::irf_events_s events,
    output logic                accept
);
    import irf_pkg::*;
    initial begin
        pins = 6'h3f;
        events = '0;
        accept = 1'b0;
    end
    task automatic set_pins(input logic [5:0] v);
        @(posedge clk);
        pins <= v;
    endtask
    // one-cycle request pulses
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        events <= irf_events_s'(v);
        @(posedge clk);
        events <= '0;
    endtask
    task automatic take();
        @(posedge clk);
        accept <= 1'b1;
        @(posedge clk);
        accept <= 1'b0;
    endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import irf_pkg::*;
    logic         clk;
    logic         rst;
    logic [3:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_write;
    logic         reg_read;
    logic [7:0]   reg_rdata;
    logic [5:0]   pins;
    irf_events_s  events;
    logic         accept;
    irf_request_s cpu_req;
    logic         global_mask;
    int           fail_count = 0;
    int           checks = 0;

    interrupt_request_flag_unit dut_u (.CORE_CLK(clk), .RESET(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata), .EXTERNAL_INTERRUPT_PINS(pins),
        .PERIPH_EVENTS(events), .CPU_ACCEPT(accept), .CPU_REQUEST(cpu_req), .GLOBAL_MASK(global_mask));
    irf_far_model far_u (.clk(clk), .pins(pins), .events(events), .accept(accept));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic req(input string what, input logic [7:0] exp);
        repeat (3) @(posedge clk);
        #1 chk(what, exp, {3'h0, cpu_req});
    endtask

    task automatic t_regs();
        rd("ext flags", IRF_ADDR_EXT_FLAGS, 8'hc0);
        rd("timer flags", IRF_ADDR_TMR_FLAGS, 8'h00);
        wr(IRF_ADDR_EXT_FLAGS, 8'hff);
        wr(IRF_ADDR_PER_FLAGS, 8'h00);
        rd("ext flags", IRF_ADDR_EXT_FLAGS, 8'hc0);
        rd("periph flags", IRF_ADDR_PER_FLAGS, 8'h3c);
        rd("unmapped", 4'hf, 8'h00);
    endtask
    // each source alone, its bit only
    task automatic t_events();
        logic [7:0] te;
        logic [7:0] pe;
        for (int i = 0; i < 10; i++) begin
            te = (i >= 5) ? 8'(1 << (i - 5)) : ((i == 4) ? 8'h20 : 8'h00);
            pe = 8'h3c | ((i == 3) ? 8'h80 : (i == 2) ? 8'h40 : (i < 2) ? 8'(1 << i) : 8'h00);
            wr(IRF_ADDR_TMR_FLAGS, 8'h3f);
            wr(IRF_ADDR_PER_FLAGS, 8'hff);
            far_u.pulse(10'h001 << i);
            rd("timer flags", IRF_ADDR_TMR_FLAGS, te);
            rd("periph flags", IRF_ADDR_PER_FLAGS, pe);
            wr(IRF_ADDR_TMR_FLAGS, 8'h00);
            wr(IRF_ADDR_PER_FLAGS, 8'h00);
        end
        fork
            wr(IRF_ADDR_PER_FLAGS, 8'h00);
            far_u.pulse(10'h008);
        join
        rd("set against clear", IRF_ADDR_PER_FLAGS, 8'hbc);
        rd("timer cleared", IRF_ADDR_TMR_FLAGS, 8'h00);
    endtask
    task automatic t_pins();
        far_u.set_pins(6'h00);
        repeat (6) @(posedge clk);
        rd("pins unused", IRF_ADDR_EXT_FLAGS, 8'hc0);
        far_u.set_pins(6'h3f);
        wr(IRF_ADDR_PORT_MODE, 8'h3f);
        far_u.set_pins(6'h00);
        repeat (6) @(posedge clk);
        rd("falling edges", IRF_ADDR_EXT_FLAGS, 8'hff);
        wr(IRF_ADDR_EXT_FLAGS, 8'h00);
        wr(IRF_ADDR_EDGE_SEL, 8'hff);
        rd("edge select", IRF_ADDR_EDGE_SEL, 8'hff);
        far_u.set_pins(6'h3f);
        repeat (6) @(posedge clk);
        rd("rising edges", IRF_ADDR_EXT_FLAGS, 8'hd3);
    endtask
    task automatic t_cpu();
        wr(IRF_ADDR_CONTROL, 8'h00);
        req("all disabled", 8'h00);
        wr(IRF_ADDR_EXT_ENABLE, 8'h10);
        req("line four", 8'h14);
        wr(IRF_ADDR_EXT_ENABLE, 8'h3f);
        req("line zero first", 8'h10);
        far_u.take();
        req("held off", 8'h00);
        chk("mask", 8'h01, {7'h00, global_mask});
        rd("kept on accept", IRF_ADDR_EXT_FLAGS, 8'hd3);
        wr(IRF_ADDR_EXT_FLAGS, 8'hfe);
        wr(IRF_ADDR_CONTROL, 8'h00);
        req("line one next", 8'h11);
        wr(IRF_ADDR_EXT_ENABLE, 8'h00);
        wr(IRF_ADDR_PER_ENABLE, 8'h80);
        req("converter alone", 8'h1f);
        far_u.take();
        req("internal accept", 8'h1f);
        chk("mask internal", 8'h00, {7'h00, global_mask});
    endtask
    // second reset in mid-run, with flags and enables set
    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd("flags after reset", IRF_ADDR_EXT_FLAGS, 8'hc0);
        rd("enables after reset", IRF_ADDR_EXT_ENABLE, 8'hc0);
        rd("mask after reset", IRF_ADDR_CONTROL, 8'h01);
        chk("request after reset", 8'h00, {3'h0, cpu_req});
    endtask
    task automatic t_noise();
        wr(IRF_ADDR_CONTROL, 8'h03);
        wr(IRF_ADDR_EDGE_SEL, 8'h00);
        wr(IRF_ADDR_PORT_MODE, 8'h01);
        wr(IRF_ADDR_EXT_FLAGS, 8'h00);
        far_u.set_pins(6'h3e);
        repeat (3) @(posedge clk);
        far_u.set_pins(6'h3f);
        repeat (600) @(posedge clk);
        rd("glitch", IRF_ADDR_EXT_FLAGS, 8'hc0);
        far_u.set_pins(6'h3e);
        repeat (600) @(posedge clk);
        rd("steady low", IRF_ADDR_EXT_FLAGS, 8'hc1);
    endtask

    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_events();
        t_pins();
        t_cpu();
        t_reset();
        t_noise();
        stop_test();
    end
endmodule
